/* video_dac_front.sv */
// Behaviour
// R1: The retrace gate and the green tip control are sampled on the rising clock edge just like the pixel codes.
// R2: The green tip control travels the same pipeline as the retrace gate and the codes so all act on the output together.
// R3: Sampled inputs pass one pipeline stage and the output levels change on the clock edge after the sampling edge.
// R4: While the sampled retrace gate is low every pixel code is ignored; red and blue sit at the blanking level and green carries only any sync current.
// R5: With the retrace gate high each code rides on a pedestal, and with it low both code and pedestal are removed.
// R6: With the green tip control high a sync current worth forty IRE is added to the green output only.
// R7: With the green tip control low the sync current is off so a blanked green output falls to zero during the tip.
// R8: The sync current feeds only the green channel and red and blue ignore the green tip control.
// R9: The green tip control never overrides codes or the retrace gate and only adds or removes the sync current.
// R10: The controller drives the green tip control low only while the retrace gate holds the outputs blanked.
// R11: A system with no sync on green holds the green tip control low all the time.
// R12: There are three identical ten-bit channels for red, green and blue, each fed by its own code bus.
// R13: All three codes and both controls are captured on one edge so the channel outputs update together.
`timescale 1ns/1ps
`include "video_front_params.svh"

module video_dac_front
    import video_front_pkg::*;
#(
    parameter int     CODE_W       = `CODE_W,
    parameter level_t PEDESTAL_LSB = `PEDESTAL_LSB,
    parameter level_t SYNC_LSB     = `SYNC_LSB
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [CODE_W-1:0] red_code_in,
    input  wire logic [CODE_W-1:0] green_code_in,
    input  wire logic [CODE_W-1:0] blue_code_in,
    input  wire logic              blank_n_in,
    input  wire logic              sync_n_in,
    input  wire logic              in_valid,
    output logic                   in_ready,
    output level_t                 red_level,
    output level_t                 green_level,
    output level_t                 blue_level,
    output logic                   out_valid,
    input  wire logic              out_ready
);
    // ==========================================================
    // Sampling stage
    // The inputs come from logic on this same clock, so they are captured directly.
    pixel_word_t in_word;
    pixel_word_t head_word;
    logic        head_valid;
    logic        load_out;
    logic        in_take;

    assign in_word = {sync_n_in, blank_n_in, blue_code_in, green_code_in, red_code_in}; // see R2, see R13
    assign in_take = in_valid && in_ready;

    pixel_skid_buffer #(
        .WIDTH (`WORD_W),
        .DEPTH (`BUF_DEPTH)
    ) u_buf (
        .clk      (clk),
        .rst      (rst),
        .wr_data  (in_word), // see R1
        .wr_valid (in_valid),
        .wr_ready (in_ready),
        .rd_data  (head_word),
        .rd_valid (head_valid),
        .rd_ready (load_out)
    );

    // ==========================================================
    // Level computation
    // One shared function keeps the three channels identical; only green gets the sync term.
    function automatic level_t chan_level(input logic [CODE_W-1:0] code,
                                          input logic              blank_n,
                                          input logic              sync_on);
        level_t lvl;
        lvl = `BLANK_LEVEL;
        if (blank_n) begin
            lvl = level_t'(PEDESTAL_LSB + level_t'(code)); // see R5
        end
        if (sync_on) begin
            lvl = level_t'(lvl + SYNC_LSB); // see R6, see R9
        end
        return lvl;
    endfunction

    logic [CODE_W-1:0] h_red;
    logic [CODE_W-1:0] h_green;
    logic [CODE_W-1:0] h_blue;
    logic              h_blank_n;
    logic              h_sync_n;

    assign h_red     = head_word[`F_RED_LSB +: CODE_W]; // see R12
    assign h_green   = head_word[`F_GREEN_LSB +: CODE_W];
    assign h_blue    = head_word[`F_BLUE_LSB +: CODE_W];
    assign h_blank_n = head_word[`F_BLANK_N];
    assign h_sync_n  = head_word[`F_SYNC_N];

    // ==========================================================
    // Output stage
    // A stall by the converter side holds the stage, and the buffer absorbs up to two words behind it.
    localparam int NCHAN = 3;

    level_t            level_q  [NCHAN];
    logic [CODE_W-1:0] h_code   [NCHAN];
    logic              sync_sel [NCHAN];
    logic              out_valid_q;

    assign h_code[0]   = h_red;
    assign h_code[1]   = h_green;
    assign h_code[2]   = h_blue;

    // Only the green converter owns the sync current source.
    assign sync_sel[0] = 1'b0;     // see R8
    assign sync_sel[1] = h_sync_n; // see R6, see R7
    assign sync_sel[2] = 1'b0;     // see R8

    assign load_out    = head_valid && (!out_valid_q || out_ready); // see R3
    assign out_valid   = out_valid_q;
    assign red_level   = level_q[0];
    assign green_level = level_q[1];
    assign blue_level  = level_q[2];

    // ==========================================================
    // Channel registers
    // All three registers load on the same edge, which keeps the colours of one pixel aligned.
    generate
        for (genvar c = 0; c < NCHAN; c++) begin : g_chan
            always_ff @(posedge clk) begin
                if (rst) begin
                    level_q[c] <= `BLANK_LEVEL;
                end else if (load_out) begin
                    level_q[c] <= chan_level(h_code[c], h_blank_n, sync_sel[c]); // see R4, see R9, see R13
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            out_valid_q <= 1'b0;
        end else if (load_out) begin
            out_valid_q <= 1'b1;
        end else if (out_ready) begin
            out_valid_q <= 1'b0;
        end
    end

    // ==========================================================
    // Checks
    // Expected levels are rebuilt from the parameters, so a slip in the shared level function shows up here.
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence take_into_idle_s;
        in_take && !head_valid && (!out_valid_q || out_ready);
    endsequence

    sequence out_shows_s;
        load_out ##1 out_valid_q;
    endsequence

    sequence blank_load_s;
        load_out && !h_blank_n;
    endsequence

    sequence stall_s;
        out_valid_q && !out_ready;
    endsequence

    a_one_stage_latency: assert property (take_into_idle_s |=> out_shows_s) // see R3
        else $error("sampled pixel did not reach the output one edge later");

    a_codes_together: assert property (take_into_idle_s |-> ##2 // see R13
            level_q[0] == ($past(blank_n_in, 2) ? level_t'(PEDESTAL_LSB + level_t'($past(red_code_in, 2))) : 12'h000))
        else $error("red level does not match the code sampled with it");

    a_blank_forces_zero: assert property (blank_load_s |=> // see R4
            level_q[0] == `BLANK_LEVEL && level_q[2] == `BLANK_LEVEL)
        else $error("blanked red or blue output is not at the blanking level");

    a_blank_green_tip: assert property (blank_load_s |=> // see R7
            level_q[1] == ($past(h_sync_n) ? SYNC_LSB : `BLANK_LEVEL))
        else $error("blanked green output is not at the sync or tip level");

    a_pedestal_added: assert property (load_out && h_blank_n |=> // see R5
            level_q[2] == level_t'(PEDESTAL_LSB + level_t'($past(h_blue))))
        else $error("blue output lacks the pedestal offset");

    a_green_sync_on: assert property (load_out && h_sync_n |=> // see R6
            level_q[1] == level_t'(($past(h_blank_n) ? level_t'(PEDESTAL_LSB + level_t'($past(h_green))) : 12'h000)
                                   + SYNC_LSB))
        else $error("green output lacks the sync current");

    a_green_tip_zero: assert property (load_out && !h_sync_n && !h_blank_n |=> level_q[1] == 12'h000) // see R7
        else $error("green sync tip is not at zero");

    a_red_blue_no_sync: assert property (load_out && h_blank_n |=> // see R8
            level_q[0] == level_t'(PEDESTAL_LSB + level_t'($past(h_red)))
            && level_q[2] == level_t'(PEDESTAL_LSB + level_t'($past(h_blue))))
        else $error("red or blue output moved with the green tip control");

    a_sync_keeps_code: assert property (load_out && h_blank_n && h_sync_n |=> // see R9
            level_q[1] > level_t'(SYNC_LSB + level_t'($past(h_green))))
        else $error("sync current replaced the green code");

    // The reference uses the pins as they stood at the take edge, two edges back.
    a_same_latency: assert property (take_into_idle_s |-> ##2 // see R2, see R1
            level_q[1] == level_t'(($past(blank_n_in, 2) ? level_t'(PEDESTAL_LSB + level_t'($past(green_code_in, 2)))
                                                         : 12'h000)
                                   + ($past(sync_n_in, 2) ? SYNC_LSB : 12'h000)))
        else $error("green tip control took effect on a different pixel");

    a_hold_on_stall: assert property (stall_s |=> // see R3
            $stable(level_q[0]) && $stable(level_q[1]) && $stable(level_q[2]) && out_valid_q)
        else $error("output changed while the converter side stalled");

    a_valid_drops: assert property (out_valid_q && out_ready && !head_valid |=> !out_valid_q) // see R3
        else $error("output word was shown twice");

    // A full buffer can only arise behind a stalled output word.
    a_full_refuses: assert property (!in_ready |-> head_valid && out_valid_q) // see R3
        else $error("input refused while the pipeline had room");
endmodule

/* video_front_params.svh */
`ifndef VIDEO_FRONT_PARAMS_SVH
`define VIDEO_FRONT_PARAMS_SVH

// ==========================================================
// Widths
`define CODE_W        10
`define LEVEL_W       12
`define WORD_W        32

// ==========================================================
// Field positions inside a buffered pixel word
`define F_RED_LSB     0
`define F_GREEN_LSB   10
`define F_BLUE_LSB    20
`define F_BLANK_N     30
`define F_SYNC_N      31

// ==========================================================
// Output current levels in code steps
`define PEDESTAL_LSB  12'h054
`define SYNC_LSB      12'h1bb
`define BLANK_LEVEL   12'h000

// ==========================================================
// Buffer
`define BUF_DEPTH     2

`endif

/* video_front_pkg.sv */
package video_front_pkg;
    typedef logic [9:0]  chan_code_t;
    typedef logic [11:0] level_t;
    typedef logic [31:0] pixel_word_t;
endpackage

/* pixel_skid_buffer.sv */
`timescale 1ns/1ps
`include "video_front_params.svh"

module pixel_skid_buffer #(
    parameter int WIDTH = `WORD_W,
    parameter int DEPTH = `BUF_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic             wr_valid,
    output logic                  wr_ready,
    output logic [WIDTH-1:0]      rd_data,
    output logic                  rd_valid,
    input  wire logic             rd_ready
);
    localparam int PW = (DEPTH > 2) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_ptr_q;
    logic [PW-1:0]    rd_ptr_q;
    logic [CW-1:0]    count_q;
    logic             push;
    logic             pop;

    assign wr_ready = (count_q != CW'(DEPTH));
    assign rd_valid = (count_q != '0);
    assign rd_data  = mem_q[rd_ptr_q];
    assign push     = wr_valid && wr_ready;
    assign pop      = rd_valid && rd_ready;

    // ==========================================================
    // Storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= wr_data;
        end
    end

    // ==========================================================
    // Pointers and fill count
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : PW'(wr_ptr_q + 1'b1);
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : PW'(rd_ptr_q + 1'b1);
            end
            if (push && !pop) begin
                count_q <= CW'(count_q + 1'b1);
            end else if (pop && !push) begin
                count_q <= CW'(count_q - 1'b1);
            end
        end
    end
endmodule

/* pixel_source.sv */
`timescale 1ns/1ps
module pixel_source
    import video_front_pkg::*;
(
    input  wire logic clk,
    input  wire logic in_ready,
    output chan_code_t red,
    output chan_code_t green,
    output chan_code_t blue,
    output logic       blank_n,
    output logic       sync_n,
    output logic       valid
);
    logic busy    = 1'b0;
    logic no_sync = 1'b0;
    initial begin
        {red, green, blue, blank_n, sync_n, valid} = '0;
    end
    // ==========================================================
    // Idle lines
    // Between words valid drops and the three code buses invert on every falling edge; blank_n and sync_n hold the last word's values.
    always @(negedge clk) begin
        if (!busy) begin
            valid = 1'b0;
            {red, green, blue} = ~{red, green, blue};
        end
    end
    // ==========================================================
    // Word transfer
    task automatic push(input logic [31:0] w);
        busy = 1'b1;
        @(negedge clk);
        {blank_n, blue, green, red} = w[30:0];
        // A system without sync on green ties the control low throughout.
        sync_n = no_sync ? 1'b0 : (w[31] | w[30]);
        valid = 1'b1;
        @(posedge clk);
        while (in_ready !== 1'b1) @(posedge clk);
        busy = 1'b0;
    endtask
endmodule

/* video_dac_front_tb.sv */
`timescale 1ns/1ps
`include "video_front_params.svh"
module video_dac_front_tb;
    import video_front_pkg::*;
    logic        clk       = 1'b0;
    logic        rst       = 1'b1;
    logic        out_ready = 1'b0;
    chan_code_t  r, g, b;
    logic        bn, sn, iv, ir, ov;
    level_t      rl, gl, bll;
    logic [35:0] e;
    logic [35:0] exp_q[$];
    int          err_total = 0;
    int          tests_run = 0;
    always #10 clk = ~clk;
    pixel_source src (.clk(clk), .in_ready(ir), .red(r), .green(g), .blue(b),
                      .blank_n(bn), .sync_n(sn), .valid(iv));
    video_dac_front uut (.clk(clk), .rst(rst), .red_code_in(r), .green_code_in(g), .blue_code_in(b),
                         .blank_n_in(bn), .sync_n_in(sn), .in_valid(iv), .in_ready(ir), .red_level(rl),
                         .green_level(gl), .blue_level(bll), .out_valid(ov), .out_ready(out_ready));
    // ==========================================================
    // Helpers
    task automatic summarize();
        if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input level_t got, input level_t want);
        tests_run++;
        if (got !== want) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, want);
        end
    endtask
    task automatic send(input chan_code_t cr, cg, cb, input logic b_n, s_n);
        level_t p;
        p = b_n ? `PEDESTAL_LSB : 12'h000;
        exp_q.push_back({b_n ? p + 12'(cr) : p, (b_n ? p + 12'(cg) : p) + (s_n ? `SYNC_LSB : 12'h000),
                         b_n ? p + 12'(cb) : p});
        src.push({s_n, b_n, cb, cg, cr});
    endtask
    task automatic drain();
        for (int i = 0; i < 40 && exp_q.size() != 0; i++) @(posedge clk);
        check(12'(exp_q.size()), 12'h000);
    endtask
    // Every accepted output word is compared with the queue in order.
    always @(posedge clk) begin
        if (!rst && ov === 1'b1 && out_ready === 1'b1) begin
            e = exp_q.size() != 0 ? exp_q.pop_front() : 36'hfff_fff_fff;
            check(rl, e[35:24]);
            check(gl, e[23:12]);
            check(bll, e[11:0]);
        end
    end
    // ==========================================================
    // Scenarios
    task automatic t_reset();
        repeat (4) @(negedge clk);
        check({ir, ov, gl[9:0]}, 12'h800);
        @(negedge clk) rst = 1'b0;
    endtask
    task automatic t_latency();
        @(negedge clk) out_ready = 1'b1;
        send(10'h001, 10'h002, 10'h003, 1'b1, 1'b1);
        #1 check({11'h0, ov}, 12'h000);
        @(posedge clk);
        #1 check({11'h0, ov}, 12'h001);
        drain();
    endtask
    task automatic t_codes();
        chan_code_t c[4];
        c = '{10'h000, 10'h3ff, 10'h200, 10'h155};
        for (int k = 0; k < 12; k++) begin
            send(c[k % 4], ~c[k % 4], c[k % 4] ^ 10'h2aa, k < 4, k < 8);
        end
        drain();
    endtask
    task automatic t_no_sync();
        src.no_sync = 1'b1;
        for (int k = 0; k < 4; k++) begin
            send(10'h3ff - 10'(k), 10'h3ff, 10'(k), k[0], 1'b0);
        end
        drain();
        src.no_sync = 1'b0;
    endtask
    task automatic t_stall();
        @(negedge clk) out_ready = 1'b0;
        fork
            for (int i = 0; i < 4; i++) send(10'h100 + 10'(i), 10'h080, 10'h3ff, 1'b1, 1'b1);
        join_none
        repeat (10) @(posedge clk);
        #1 check({11'h0, ir}, 12'h000);
        check(rl, `PEDESTAL_LSB + 12'h100);
        @(negedge clk) out_ready = 1'b1;
        drain();
    endtask
    initial begin
        t_reset();
        t_latency();
        t_codes();
        t_no_sync();
        t_stall();
        summarize();
    end
    // The whole run takes well under a thousand cycles.
    initial begin
        #100000;
        err_total++;
        summarize();
    end
endmodule
